//--- bsw_regs.vh
// register offsets, field positions and codes for the bank-switch control
`ifndef BSW_REGS_VH
`define BSW_REGS_VH

`define BSW_CTRL_OFFSET 8'h29
`define BSW_CTRL_RESET 16'hF800
`define BSW_CTRL_WMASK 16'hF807
`define BSW_CMP_HI 15
`define BSW_CMP_LO 12
`define BSW_GAP_BIT 11
`define BSW_HBH_BIT 2
`define BSW_BH_BIT 1
`define BSW_OFF_BIT 0
`define BSW_BANK_HI 15
`define BSW_BANK_LO 12
`define BSW_SPACE_DATA 1'b0
`define BSW_SPACE_PROG 1'b1
`define BSW_ZERO16 16'h0000
`define BSW_ZERO4 4'h0

`endif

//--- bsw_bus_holder.v
// keeper that drives the last seen level back onto undriven lines
`timescale 1ns/1ps
module bsw_bus_holder #(
  parameter WIDTH = 16
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_enable,
  input wire [WIDTH-1:0] i_line,
  input wire i_driven,
  output reg [WIDTH-1:0] o_keep,
  output reg o_keep_oe
);

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_keep <= {WIDTH{1'b0}};
      o_keep_oe <= 1'b0;
    end else begin
      // capture only while a real driver owns the lines
      if (i_driven) begin
        o_keep <= i_line;
      end
      o_keep_oe <= i_enable & ~i_driven;
    end
  end

endmodule

//--- bsw_ctrl.v
// bank-switch wait insertion, bus holders and external bus-off control
`timescale 1ns/1ps
`include "bsw_regs.vh"

module bsw_ctrl #(
  parameter ADDR_W = 16,
  parameter DATA_W = 16,
  parameter HDATA_W = 8,
  parameter HADDR_W = 16,
  parameter MMR_W = 8
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [MMR_W-1:0] i_mmr_addr,
  input wire i_mmr_wr,
  input wire i_mmr_rd,
  input wire [15:0] i_mmr_wdata,
  output reg [15:0] o_mmr_rdata,
  output reg o_mmr_rvalid,
  input wire i_acc_req,
  input wire i_acc_space,
  input wire i_acc_read,
  input wire [ADDR_W-1:0] i_acc_addr,
  input wire [DATA_W-1:0] i_acc_wdata,
  output reg o_acc_done,
  output reg [DATA_W-1:0] o_acc_rdata,
  output reg o_gap_cycle,
  output reg [ADDR_W-1:0] o_ext_addr,
  output reg o_ext_strobe,
  output reg o_ext_read,
  output reg o_ext_space,
  input wire [DATA_W-1:0] i_ext_data,
  output reg [DATA_W-1:0] o_ext_data,
  output reg o_ext_data_oe,
  input wire i_ext_data_driven,
  output wire [DATA_W-1:0] o_data_keep,
  output wire o_data_keep_oe,
  input wire i_host_16bit_mode,
  input wire [HDATA_W-1:0] i_host_data,
  input wire i_host_data_driven,
  output wire [HDATA_W-1:0] o_host_data_keep,
  output wire o_host_data_keep_oe,
  input wire [HADDR_W-1:0] i_host_addr,
  input wire i_host_addr_driven,
  output wire [HADDR_W-1:0] o_host_addr_keep,
  output wire o_host_addr_keep_oe,
  output reg o_bus_off,
  output reg o_mode_write_block
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_GAP = 2'h1;
  localparam [1:0] ST_CYCLE = 2'h2;
  localparam [1:0] ST_OFF = 2'h3;

  reg [15:0] bank_switch_control;
  reg [1:0] state;
  reg [1:0] next_state;
  reg last_valid;
  reg last_space;
  reg last_read;
  reg [ADDR_W-1:0] last_addr;
  reg need_gap;
  reg bank_cross;
  reg read_swap;
  reg data_to_prog;

  wire [3:0] bank_compare_mask;
  wire prog_data_read_gap;
  wire host_port_holder_enable;
  wire data_bus_holder_enable;
  wire external_bus_off;
  wire host_data_hold_en;
  wire host_addr_hold_en;

  // masked bank tag of an address
  function [3:0] bsw_bank_tag;
    input [ADDR_W-1:0] addr;
    input [3:0] mask;
    begin
      bsw_bank_tag = addr[`BSW_BANK_HI:`BSW_BANK_LO] & mask;
    end
  endfunction

  // register-offset decode
  function bsw_hit;
    input [MMR_W-1:0] addr;
    begin
      bsw_hit = (addr == `BSW_CTRL_OFFSET);
    end
  endfunction

  assign bank_compare_mask = bank_switch_control[`BSW_CMP_HI:`BSW_CMP_LO];
  assign prog_data_read_gap = bank_switch_control[`BSW_GAP_BIT];
  assign host_port_holder_enable = bank_switch_control[`BSW_HBH_BIT];
  assign data_bus_holder_enable = bank_switch_control[`BSW_BH_BIT];
  assign external_bus_off = bank_switch_control[`BSW_OFF_BIT];

  // control register: masked write, registered read
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bank_switch_control <= `BSW_CTRL_RESET;
      o_mmr_rdata <= `BSW_ZERO16;
      o_mmr_rvalid <= 1'b0;
    end else begin
      if (i_mmr_wr && bsw_hit(i_mmr_addr)) begin
        bank_switch_control <= (bank_switch_control & ~`BSW_CTRL_WMASK) |
                               (i_mmr_wdata & `BSW_CTRL_WMASK);
      end
      o_mmr_rvalid <= i_mmr_rd;
      if (i_mmr_rd && bsw_hit(i_mmr_addr)) begin
        o_mmr_rdata <= bank_switch_control & `BSW_CTRL_WMASK;
      end else begin
        o_mmr_rdata <= `BSW_ZERO16;
      end
    end
  end

  // gap decision for the pending request
  always @* begin
    bank_cross = last_valid && (last_space == i_acc_space) &&
                 (bsw_bank_tag(i_acc_addr, bank_compare_mask) !=
                  bsw_bank_tag(last_addr, bank_compare_mask));
    read_swap = prog_data_read_gap && last_valid && last_read &&
                i_acc_read && (last_space != i_acc_space);
    data_to_prog = prog_data_read_gap && last_valid &&
                   (last_space == `BSW_SPACE_DATA) &&
                   (i_acc_space == `BSW_SPACE_PROG);
    need_gap = bank_cross | read_swap | data_to_prog;
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (external_bus_off) begin
          next_state = ST_OFF;
        end else if (i_acc_req) begin
          next_state = need_gap ? ST_GAP : ST_CYCLE;
        end
      end
      ST_GAP: begin
        next_state = ST_CYCLE;
      end
      ST_CYCLE: begin
        next_state = ST_IDLE;
      end
      ST_OFF: begin
        if (!external_bus_off) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer and external pin drive
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      last_valid <= 1'b0;
      last_space <= `BSW_SPACE_DATA;
      last_read <= 1'b0;
      last_addr <= {ADDR_W{1'b0}};
      o_acc_done <= 1'b0;
      o_acc_rdata <= {DATA_W{1'b0}};
      o_gap_cycle <= 1'b0;
      o_ext_addr <= {ADDR_W{1'b0}};
      o_ext_strobe <= 1'b0;
      o_ext_read <= 1'b0;
      o_ext_space <= `BSW_SPACE_DATA;
      o_ext_data <= {DATA_W{1'b0}};
      o_ext_data_oe <= 1'b0;
      o_bus_off <= 1'b0;
      o_mode_write_block <= 1'b0;
    end else begin
      state <= next_state;
      o_acc_done <= 1'b0;
      o_gap_cycle <= (next_state == ST_GAP);
      o_mode_write_block <= (next_state == ST_OFF);
      o_bus_off <= (next_state == ST_OFF);
      if (next_state == ST_CYCLE) begin
        o_ext_addr <= i_acc_addr;
        o_ext_strobe <= 1'b1;
        o_ext_read <= i_acc_read;
        o_ext_space <= i_acc_space;
        o_ext_data <= i_acc_wdata;
        o_ext_data_oe <= ~i_acc_read;
      end else if (next_state == ST_OFF) begin
        o_ext_addr <= {ADDR_W{1'b0}};
        o_ext_strobe <= 1'b0;
        o_ext_read <= 1'b0;
        o_ext_space <= `BSW_SPACE_DATA;
        o_ext_data <= {DATA_W{1'b0}};
        o_ext_data_oe <= 1'b0;
      end else begin
        o_ext_strobe <= 1'b0;
        o_ext_data_oe <= 1'b0;
      end
      if (state == ST_CYCLE) begin
        o_acc_done <= 1'b1;
        if (o_ext_read) begin
          o_acc_rdata <= i_ext_data;
        end
        last_valid <= 1'b1;
        last_space <= o_ext_space;
        last_read <= o_ext_read;
        last_addr <= o_ext_addr;
      end
    end
  end

  assign host_data_hold_en = i_host_16bit_mode | host_port_holder_enable;
  assign host_addr_hold_en = i_host_16bit_mode & host_port_holder_enable;

  bsw_bus_holder #(
    .WIDTH(DATA_W)
  ) u_data_hold (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_enable(data_bus_holder_enable),
    .i_line(i_ext_data),
    .i_driven(o_ext_data_oe | i_ext_data_driven),
    .o_keep(o_data_keep),
    .o_keep_oe(o_data_keep_oe)
  );

  bsw_bus_holder #(
    .WIDTH(HDATA_W)
  ) u_host_data_hold (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_enable(host_data_hold_en),
    .i_line(i_host_data),
    .i_driven(i_host_data_driven),
    .o_keep(o_host_data_keep),
    .o_keep_oe(o_host_data_keep_oe)
  );

  bsw_bus_holder #(
    .WIDTH(HADDR_W)
  ) u_host_addr_hold (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_enable(host_addr_hold_en),
    .i_line(i_host_addr),
    .i_driven(i_host_addr_driven),
    .o_keep(o_host_addr_keep),
    .o_keep_oe(o_host_addr_keep_oe)
  );

endmodule

//--- bsw_ctrl_monitor.sv
// assertion checker for the bank-switch control block
`timescale 1ns/1ps
module bsw_ctrl_monitor #(
  parameter ADDR_W = 16
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_mmr_rd,
  input wire [15:0] o_mmr_rdata,
  input wire o_mmr_rvalid,
  input wire o_acc_done,
  input wire o_gap_cycle,
  input wire [ADDR_W-1:0] o_ext_addr,
  input wire o_ext_strobe,
  input wire i_ext_data_driven,
  input wire o_data_keep_oe,
  input wire i_host_16bit_mode,
  input wire i_host_addr_driven,
  input wire o_host_addr_keep_oe,
  input wire o_bus_off,
  input wire o_mode_write_block
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_bus;
    o_ext_strobe && !o_gap_cycle;
  endsequence
  sequence s_end;
    !o_ext_strobe && o_acc_done;
  endsequence
  chk_gap_bus: assert property (o_gap_cycle |=> s_bus ##1 s_end)
    else $error("gap not followed by bus cycle");
  chk_cycle_end: assert property (o_ext_strobe |=> s_end)
    else $error("bus cycle did not finish");
  chk_off_quiet: assert property (
    o_bus_off |-> !o_ext_strobe && !o_acc_done && o_ext_addr == '0)
    else $error("bus active while off");
  chk_lock_off: assert property (o_mode_write_block == o_bus_off)
    else $error("mode lock differs from bus off");
  chk_off_between: assert property (
    $rose(o_bus_off) |-> !$past(o_ext_strobe) && !$past(o_gap_cycle))
    else $error("bus switched off inside a cycle");
  chk_read_ans: assert property (
    i_mmr_rd |=> o_mmr_rvalid && o_mmr_rdata[10:3] == 8'h00)
    else $error("bad register read answer");
  chk_rdata_idle: assert property (
    !o_mmr_rvalid |-> o_mmr_rdata == 16'h0000)
    else $error("read data without valid");
  chk_data_keep: assert property (
    o_data_keep_oe |-> !$past(i_ext_data_driven))
    else $error("data keeper fights a driver");
  chk_haddr_keep: assert property (o_host_addr_keep_oe |->
    $past(i_host_16bit_mode) && !$past(i_host_addr_driven))
    else $error("host address keeper wrong");
endmodule

bind bsw_ctrl bsw_ctrl_monitor #(.ADDR_W(ADDR_W)) i_bsw_ctrl_monitor (
  .i_core_clk, .i_rst_n, .i_mmr_rd, .o_mmr_rdata, .o_mmr_rvalid,
  .o_acc_done, .o_gap_cycle, .o_ext_addr, .o_ext_strobe,
  .i_ext_data_driven, .o_data_keep_oe, .i_host_16bit_mode,
  .i_host_addr_driven, .o_host_addr_keep_oe, .o_bus_off,
  .o_mode_write_block);

//--- bsw_ext_mem.sv
// external memory model on the parallel data bus
`timescale 1ns/1ps
module bsw_ext_mem (
  input wire i_core_clk,
  input wire [15:0] i_addr,
  input wire i_strobe,
  input wire i_read,
  input wire i_space,
  input wire [15:0] i_dev_data,
  input wire i_dev_oe,
  input wire [15:0] i_keep,
  input wire i_keep_oe,
  output wire [15:0] o_bus,
  output wire o_driven
);
  reg [15:0] mem [0:31];
  reg [15:0] last = 16'h0000;
  wire [4:0] idx = {i_space, i_addr[15:12]};
  wire mem_oe = i_strobe & i_read;
  assign o_driven = mem_oe | i_dev_oe;
  // a released bus with no keeper shows a toggling pattern
  assign o_bus = i_dev_oe ? i_dev_data : mem_oe ? mem[idx] :
    i_keep_oe ? i_keep : ~last;
  always @(posedge i_core_clk) begin
    last <= o_bus;
    if (i_strobe & ~i_read)
      mem[idx] <= i_dev_data;
  end
endmodule

//--- tb_bsw_ctrl.sv
// self-checking bench for the bank-switch control block
`timescale 1ns/1ps
module tb_bsw_ctrl;
  reg i_core_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg mw = 1'b0, mr = 1'b0, req = 1'b0, sp = 1'b0, rd = 1'b0;
  reg hm = 1'b0, hdv = 1'b0, hav = 1'b0, seen = 1'b0;
  reg [7:0] ma = 8'h00, hd = 8'h00;
  reg [15:0] md = 16'h0000, ad = 16'h0000, wd = 16'h0000;
  reg [15:0] ha = 16'h0000, n = 16'h0000;
  wire [15:0] rdat, ea, eo, bus, dk, ard, hak;
  wire [7:0] hdk;
  wire rv, done, gap, stb, erd, esp, eoe, drv, dko, hdo, hao, off, lk;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer k;
  // {space, read, gap, bank nibble} per access
  localparam [103:0] SEQ = 104'h01_21_12_22_52_62_32_22_19_0F_62_2F_22;
  bsw_ctrl i_bsw_ctrl (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_mmr_addr(ma), .i_mmr_wr(mw), .i_mmr_rd(mr), .i_mmr_wdata(md),
    .o_mmr_rdata(rdat), .o_mmr_rvalid(rv), .i_acc_req(req),
    .i_acc_space(sp), .i_acc_read(rd), .i_acc_addr(ad), .i_acc_wdata(wd),
    .o_acc_done(done), .o_acc_rdata(ard), .o_gap_cycle(gap),
    .o_ext_addr(ea), .o_ext_strobe(stb), .o_ext_read(erd),
    .o_ext_space(esp), .i_ext_data(bus), .o_ext_data(eo),
    .o_ext_data_oe(eoe), .i_ext_data_driven(drv), .o_data_keep(dk),
    .o_data_keep_oe(dko), .i_host_16bit_mode(hm), .i_host_data(hd),
    .i_host_data_driven(hdv), .o_host_data_keep(hdk),
    .o_host_data_keep_oe(hdo), .i_host_addr(ha),
    .i_host_addr_driven(hav), .o_host_addr_keep(hak),
    .o_host_addr_keep_oe(hao), .o_bus_off(off), .o_mode_write_block(lk));
  bsw_ext_mem i_bsw_ext_mem (.i_core_clk(i_core_clk), .i_addr(ea),
    .i_strobe(stb), .i_read(erd), .i_space(esp), .i_dev_data(eo),
    .i_dev_oe(eoe), .i_keep(dk), .i_keep_oe(dko), .o_bus(bus),
    .o_driven(drv));
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end
  task cmp_word(input [15:0] g, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task cmp_bit(input g, input e);
    cmp_word({15'h0000, g}, {15'h0000, e});
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task mmr(input w, input [7:0] a, input [15:0] d);
    begin
      @(posedge i_core_clk) #2;
      ma = a;
      md = d;
      mw = w;
      mr = !w;
      @(posedge i_core_clk) #2;
      // read answer stands only in the cycle after the strobe edge
      if (!w) cmp_bit(rv, 1'b1);
      if (!w) cmp_word(rdat, d);
      mw = 1'b0;
      mr = 1'b0;
    end
  endtask
  task wait_done;
    begin
      n = 16'h0000;
      seen = 1'b0;
      while (done !== 1'b1 && n < 16'h0008) begin
        @(posedge i_core_clk) #1;
        n = n + 16'h0001;
        seen = seen | (gap === 1'b1);
      end
    end
  endtask
  task acc(input [7:0] b);
    begin
      @(posedge i_core_clk) #2;
      req = 1'b1;
      sp = b[6];
      rd = b[5];
      ad = {b[3:0], 12'h000};
      wd = ad ^ 16'hA5A5 ^ {15'h0000, b[6]};
      wait_done;
      #1 req = 1'b0;
      cmp_word(n, b[4] ? 16'h0003 : 16'h0002);
      cmp_bit(seen, b[4]);
      if (b[5]) cmp_word(ard, wd);
    end
  endtask
  task hold(input m, input [15:0] c, input ed, input eh, input ea_);
    begin
      mmr(1'b1, 8'h29, c);
      hm = m;
      hdv = 1'b1;
      hav = 1'b1;
      hd = 8'h3C;
      ha = 16'h1234;
      repeat (2) @(posedge i_core_clk);
      #2 hdv = 1'b0;
      hav = 1'b0;
      hd = ~hd;
      ha = ~ha;
      repeat (2) @(posedge i_core_clk);
      #1 cmp_bit(dko, ed);
      cmp_bit(hdo, eh);
      cmp_bit(hao, ea_);
      if (ed) cmp_word(dk, 16'h85A5);
      if (eh) cmp_word({8'h00, hdk}, 16'h003C);
      if (ea_) cmp_word(hak, 16'h1234);
    end
  endtask
  initial begin
    repeat (10) @(posedge i_core_clk);
    #2 i_rst_n = 1'b1;
    mmr(1'b0, 8'h29, 16'hF800);
    mmr(1'b0, 8'h28, 16'h0000);
    mmr(1'b1, 8'h29, 16'h07FE);
    mmr(1'b0, 8'h29, 16'h0006);
    mmr(1'b1, 8'h29, 16'hF800);
    for (k = 0; k < 13; k = k + 1) begin
      if (k == 8) mmr(1'b1, 8'h29, 16'h8000);
      if (k == 12) mmr(1'b1, 8'h29, 16'h0000);
      acc(SEQ[103-8*k -: 8]);
    end
    hold(1'b0, 16'h0006, 1'b1, 1'b1, 1'b0);
    hold(1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
    hold(1'b1, 16'h0002, 1'b1, 1'b1, 1'b0);
    hold(1'b1, 16'h0006, 1'b1, 1'b1, 1'b1);
    mmr(1'b1, 8'h29, 16'h0001);
    @(posedge i_core_clk) #2 req = 1'b1;
    wait_done;
    cmp_bit(off, 1'b1);
    cmp_bit(lk, 1'b1);
    cmp_bit(done, 1'b0);
    mmr(1'b1, 8'h29, 16'h0000);
    wait_done;
    cmp_bit(done, 1'b1);
    #1 req = 1'b0;
    complete_run;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    $display("BAD %0t watchdog expired", $time);
    complete_run;
  end
endmodule
